// [verilog/sdram_burst_core.sv]
// Synchronous DRAM core: command decode, bank/row tracking, burst address
// generation, operating-mode register, read latency pipe and write buffer.
// Assumes the controller drives all command pins from logic on sys_clk.
`timescale 1ns/1ns
`default_nettype none

module sdram_write_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PTR_BITS = $clog2(DEPTH);
   logic [WIDTH-1:0] store_q [DEPTH];
   logic [PTR_BITS-1:0] wr_ptr_q;
   logic [PTR_BITS-1:0] rd_ptr_q;
   logic [PTR_BITS:0] count_q;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   wire [PTR_BITS-1:0] last_ptr = PTR_BITS'(DEPTH - 1);
   assign in_ready = (count_q != (PTR_BITS+1)'(DEPTH));
   assign out_valid = (count_q != '0);
   assign out_data = store_q[rd_ptr_q];
   always_ff @(posedge clk) begin
      if (push) begin
         store_q[wr_ptr_q] <= in_data;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == last_ptr) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == last_ptr) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push & ~pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop & ~push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule : sdram_write_fifo

// How it works
// - Four banks, each rows by columns of sixteen-bit words.
// - ACTIVE opens the row on the address lines in the selected bank.
// - READ or WRITE takes its starting column from address bits zero to eight.
// - Burst length one, two, four or eight, for both burst types.
// - Full-page bursts are sequential only and end on burst terminate.
// - Auto precharge closes the accessed row when a fixed-length burst completes.
// - A new column command is accepted every cycle, cutting the running burst.
// - Banks open and close independently, so precharge overlaps other accesses.
// - Mode register resets to all zeros (length one, sequential) until first loaded.
// - Only load-mode writes the operating-mode register; it holds otherwise.
// - Mode fields: length, type, latency, operating mode, write burst, reserved.
// - Fixed bursts wrap within an aligned block of burst length.
// - Full-page bursts wrap within the 512-column row.
// - Type bit picks sequential (incrementing, wrapping) or interleaved order.
// - Interleaved step k uses start offset xor k.
// - Burst length one accesses just the addressed column, type ignored.
// - Read data is valid two or three clocks after the READ.
// - Write burst bit set makes writes single-location; reads keep length.
// - Load-mode takes the twelve address lines as the new mode value.
module sdram_burst_core
   import sdram_core_pkg::*;
#(
   parameter int NUM_ROW_BITS = ROW_BITS,
   parameter int NUM_COL_BITS = COL_BITS,
   parameter int BUF_DEPTH = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Command pins
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [ROW_BITS-1:0] addr,
   input wire logic bank_select_low,
   input wire logic bank_select_high,
   input wire logic [MASK_BITS-1:0] dqm,
   // Data pins
   input wire logic [DATA_BITS-1:0] dq_in,
   output logic [DATA_BITS-1:0] dq_out,
   output logic [MASK_BITS-1:0] dq_oe_n,
   // Status
   output logic write_buffer_ready,
   output logic init_refresh_done,
   output logic mode_loaded,
   output logic [(1<<BANK_BITS)-1:0] banks_open
);
   localparam int NUM_BANKS = 1 << BANK_BITS;
   localparam int IDX_BITS = BANK_BITS + NUM_ROW_BITS + NUM_COL_BITS;
   localparam int FIFO_BITS = IDX_BITS + DATA_BITS + MASK_BITS;

   // Column bits that move within a burst; also the last step of a fixed burst.
   // Reserved length codes act as single-location accesses.
   function automatic logic [NUM_COL_BITS-1:0] blk_mask(input logic [2:0] len_code);
      case (len_code)
         BL_TWO: return NUM_COL_BITS'(1);
         BL_FOUR: return NUM_COL_BITS'(3);
         BL_EIGHT: return NUM_COL_BITS'(7);
         BL_PAGE: return '1;
         default: return '0;
      endcase
   endfunction : blk_mask

   // Column for step k of a burst: block bits from start, low bits stepped
   function automatic logic [NUM_COL_BITS-1:0] burst_col(
      input logic [NUM_COL_BITS-1:0] start,
      input logic [NUM_COL_BITS-1:0] step,
      input logic [2:0] len_code,
      input logic interleave
   );
      logic [NUM_COL_BITS-1:0] mask;
      logic [NUM_COL_BITS-1:0] off;
      mask = blk_mask(len_code);
      off = '0;
      if (interleave && len_code != BL_PAGE) begin
         off = (start ^ step) & mask;
      end else begin
         off = (start + step) & mask;
      end
      return (start & ~mask) | off;
   endfunction : burst_col

   // Reset release through two flops
   logic rst_sync1_q;
   logic rst_sync2_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync1_q <= 1'b0;
         rst_sync2_q <= 1'b0;
      end else begin
         rst_sync1_q <= 1'b1;
         rst_sync2_q <= rst_sync1_q;
      end
   end
   wire rst_core_n = rst_sync2_q;

   // Command decode
   wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
   wire [BANK_BITS-1:0] bank_in = {bank_select_high, bank_select_low};
   wire cmd_active = (cmd == CMD_ACTIVE);
   wire cmd_read = (cmd == CMD_READ);
   wire cmd_write = (cmd == CMD_WRITE);
   wire cmd_term = (cmd == CMD_TERMINATE);
   wire cmd_pre = (cmd == CMD_PRECHARGE);
   wire cmd_refresh = (cmd == CMD_REFRESH);
   wire cmd_load = (cmd == CMD_LOAD_MODE);
   wire pre_all = cmd_pre & addr[AP_BIT];
   // Operating-mode register and its fields
   logic [MODE_BITS-1:0] mode_q;
   wire [2:0] mode_len = mode_q[BL_MSB:BL_LSB];
   wire mode_ilv = mode_q[BURST_TYPE_POS];
   wire [2:0] mode_lat = mode_q[LAT_MSB:LAT_LSB];
   wire write_single = mode_q[WRITE_BURST_POS];
   wire lat_three = (mode_lat == LAT_THREE);
   // Bank state
   logic [NUM_BANKS-1:0] open_q;
   logic [NUM_ROW_BITS-1:0] open_row_q [NUM_BANKS];

   // Burst state
   logic busy_q;
   logic wr_q;
   logic ap_q;
   logic ilv_q;
   logic [2:0] len_q;
   logic [BANK_BITS-1:0] bank_q;
   logic [NUM_COL_BITS-1:0] start_q;
   logic [NUM_COL_BITS-1:0] step_q;
   wire col_cmd = (cmd_read | cmd_write) & open_q[bank_in];
   wire [2:0] len_new = (cmd_write & write_single) ? BL_ONE : mode_len;
   wire [NUM_COL_BITS-1:0] start_new = addr[NUM_COL_BITS-1:0];
   // A terminate or precharge edge carries no beat of the burst it stops
   wire stop_burst = cmd_term | (cmd_pre & (addr[AP_BIT] | bank_in == bank_q));
   wire beat = col_cmd | (busy_q & ~stop_burst);
   wire beat_wr = col_cmd ? cmd_write : wr_q;
   wire [BANK_BITS-1:0] beat_bank = col_cmd ? bank_in : bank_q;
   wire [NUM_COL_BITS-1:0] beat_col = col_cmd ? burst_col(start_new, '0, len_new, mode_ilv)
                                              : burst_col(start_q, step_q, len_q, ilv_q);
   wire [IDX_BITS-1:0] beat_idx = {beat_bank, open_row_q[beat_bank], beat_col};
   wire busy_last = busy_q & (len_q != BL_PAGE) & (step_q == blk_mask(len_q));
   // Auto precharge fires when a fixed burst completes, never on full page
   wire ap_now_single = col_cmd & addr[AP_BIT] & (blk_mask(len_new) == '0);
   wire ap_now_burst = ~col_cmd & ~stop_burst & busy_last & ap_q;
   wire ap_close = ap_now_single | ap_now_burst;
   wire [BANK_BITS-1:0] ap_bank = ap_now_single ? bank_in : bank_q;

   always_ff @(posedge sys_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         mode_q <= MODE_RESET;
      end else if (cmd_load) begin
         mode_q <= addr;
      end
   end

   genvar gb;
   generate
      for (gb = 0; gb < NUM_BANKS; gb++) begin : g_bank
         always_ff @(posedge sys_clk or negedge rst_core_n) begin
            if (!rst_core_n) begin
               open_q[gb] <= 1'b0;
               open_row_q[gb] <= '0;
            end else if (cmd_active && bank_in == BANK_BITS'(gb)) begin
               open_q[gb] <= 1'b1;
               open_row_q[gb] <= addr[NUM_ROW_BITS-1:0];
            end else if (cmd_pre && (addr[AP_BIT] || bank_in == BANK_BITS'(gb))) begin
               open_q[gb] <= 1'b0;
            end else if (ap_close && ap_bank == BANK_BITS'(gb)) begin
               open_q[gb] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         busy_q <= 1'b0;
         wr_q <= 1'b0;
         ap_q <= 1'b0;
         ilv_q <= 1'b0;
         len_q <= BL_ONE;
         bank_q <= '0;
         start_q <= '0;
         step_q <= '0;
      end else if (col_cmd) begin
         busy_q <= (blk_mask(len_new) != '0);
         wr_q <= cmd_write;
         ap_q <= addr[AP_BIT];
         ilv_q <= mode_ilv;
         len_q <= len_new;
         bank_q <= bank_in;
         start_q <= start_new;
         step_q <= NUM_COL_BITS'(1);
      end else if (stop_burst || busy_last) begin
         busy_q <= 1'b0;
      end else if (busy_q) begin
         step_q <= step_q + 1'b1;
      end
   end

   // Initialisation progress as seen by the device
   init_state_e init_q;
   logic [1:0] refresh_cnt_q;
   always_ff @(posedge sys_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         init_q <= INIT_WAIT_PALL;
         refresh_cnt_q <= '0;
      end else begin
         case (init_q)
            INIT_WAIT_PALL: begin
               if (pre_all) begin
                  init_q <= INIT_REFRESH;
               end
            end
            INIT_REFRESH: begin
               if (cmd_refresh) begin
                  refresh_cnt_q <= refresh_cnt_q + 1'b1;
                  if (refresh_cnt_q == INIT_REFRESHES - 2'h1) begin
                     init_q <= INIT_MODE_READY;
                  end
               end
            end
            INIT_MODE_READY: begin
               if (cmd_load) begin
                  init_q <= INIT_OPERATING;
               end
            end
            INIT_OPERATING: init_q <= INIT_OPERATING;
            default: init_q <= INIT_WAIT_PALL;
         endcase
      end
   end

   // Single-port array behind a write buffer: a read beat holds the drain, so a
   // read right behind a write to the same column may see the older word.
   wire [DATA_BITS-1:0] rd_word;
   wire buf_in_valid = beat & beat_wr;
   wire buf_out_valid;
   wire [FIFO_BITS-1:0] buf_out;
   wire buf_drain = ~(beat & ~beat_wr);
   wire [IDX_BITS-1:0] drain_idx = buf_out[FIFO_BITS-1 -: IDX_BITS];
   wire [DATA_BITS-1:0] drain_data = buf_out[MASK_BITS +: DATA_BITS];
   wire [MASK_BITS-1:0] drain_mask = buf_out[MASK_BITS-1:0];

   sdram_write_fifo #(
      .WIDTH(FIFO_BITS),
      .DEPTH(BUF_DEPTH)
   ) u_write_fifo (
      .clk(sys_clk),
      .rst_n(rst_core_n),
      .in_valid(buf_in_valid),
      .in_ready(write_buffer_ready),
      .in_data({beat_idx, dq_in, dqm}),
      .out_valid(buf_out_valid),
      .out_ready(buf_drain),
      .out_data(buf_out)
   );

   genvar gm;
   generate
      for (gm = 0; gm < MASK_BITS; gm++) begin : g_lane
         logic [BYTE_BITS-1:0] lane_q [1 << IDX_BITS];
         assign rd_word[gm*BYTE_BITS +: BYTE_BITS] = lane_q[beat_idx];
         always_ff @(posedge sys_clk) begin
            if (buf_out_valid && buf_drain && !drain_mask[gm]) begin
               lane_q[drain_idx] <= drain_data[gm*BYTE_BITS +: BYTE_BITS];
            end
         end
      end
   endgenerate
   // Read latency pipe: stage 0 holds the beat taken at the command edge
   logic [DATA_BITS-1:0] pipe_data_q [2];
   logic [1:0] pipe_vld_q;
   logic [MASK_BITS-1:0] dqm_q;
   wire [DATA_BITS-1:0] sel_data = lat_three ? pipe_data_q[1] : pipe_data_q[0];
   wire sel_vld = lat_three ? pipe_vld_q[1] : pipe_vld_q[0];

   always_ff @(posedge sys_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         pipe_data_q[0] <= '0;
         pipe_data_q[1] <= '0;
         pipe_vld_q <= '0;
         dqm_q <= '1;
         dq_out <= '0;
         dq_oe_n <= '1;
      end else begin
         pipe_data_q[0] <= rd_word;
         pipe_data_q[1] <= pipe_data_q[0];
         pipe_vld_q <= {pipe_vld_q[0], beat & ~beat_wr};
         dqm_q <= dqm;
         dq_out <= sel_data;
         dq_oe_n <= ~({MASK_BITS{sel_vld}} & ~dqm_q);
      end
   end

   assign init_refresh_done = init_q[1];
   assign mode_loaded = (init_q == INIT_OPERATING);
   assign banks_open = open_q;

endmodule : sdram_burst_core

`default_nettype wire

// [verilog/sdram_core_pkg.sv]
// Constants shared by the synchronous DRAM core: pin command codes,
// operating-mode field layout, burst and latency encodings, init states.
// Assumes command pins are sampled on the rising edge of the core clock.
package sdram_core_pkg;

   // Array geometry
   localparam int BANK_BITS = 2;
   localparam int ROW_BITS = 12;
   localparam int COL_BITS = 9;
   localparam int DATA_BITS = 16;
   localparam int MASK_BITS = 2;
   localparam int BYTE_BITS = 8;

   // Commands as {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_ACTIVE = 4'h3;
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_TERMINATE = 4'h6;
   localparam logic [3:0] CMD_PRECHARGE = 4'h2;
   localparam logic [3:0] CMD_REFRESH = 4'h1;
   localparam logic [3:0] CMD_LOAD_MODE = 4'h0;

   // Address bit that requests auto precharge or precharge of all banks
   localparam int AP_BIT = 10;

   // Operating-mode field positions
   localparam int MODE_BITS = 12;
   localparam int BL_LSB = 0;
   localparam int BL_MSB = 2;
   localparam int BURST_TYPE_POS = 3;
   localparam int LAT_LSB = 4;
   localparam int LAT_MSB = 6;
   localparam int OP_MODE_LOW_POS = 7;
   localparam int OP_MODE_HIGH_POS = 8;
   localparam int WRITE_BURST_POS = 9;
   localparam logic [MODE_BITS-1:0] MODE_RESET = 12'h000;

   // Burst length codes
   localparam logic [2:0] BL_ONE = 3'h0;
   localparam logic [2:0] BL_TWO = 3'h1;
   localparam logic [2:0] BL_FOUR = 3'h2;
   localparam logic [2:0] BL_EIGHT = 3'h3;
   localparam logic [2:0] BL_PAGE = 3'h7;

   // Read latency codes
   localparam logic [2:0] LAT_TWO = 3'h2;
   localparam logic [2:0] LAT_THREE = 3'h3;

   // Refresh cycles expected during initialisation
   localparam logic [1:0] INIT_REFRESHES = 2'h2;

   typedef enum logic [1:0] {
      INIT_WAIT_PALL = 2'b00,
      INIT_REFRESH = 2'b01,
      INIT_MODE_READY = 2'b10,
      INIT_OPERATING = 2'b11
   } init_state_e;

endpackage : sdram_core_pkg

// [verification/sdram_burst_core_monitor.sv]
// Concurrent checks on the SDRAM core's top ports.
// Assumes one clock, sys_clk, and the raw active-low rst_n.
`timescale 1ns/1ns
`default_nettype none
module sdram_burst_core_monitor
   import sdram_core_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Command pins
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [ROW_BITS-1:0] addr,
   input wire logic bank_select_low,
   input wire logic bank_select_high,
   // Outputs
   input wire logic [MASK_BITS-1:0] dq_oe_n,
   input wire logic init_refresh_done,
   input wire logic mode_loaded,
   input wire logic [(1<<BANK_BITS)-1:0] banks_open
);
   logic [3:0] cmd;
   logic [1:0] bank;
   logic read_ok;
   logic lat3_q;
   assign cmd = {cs_n, ras_n, cas_n, we_n};
   assign bank = {bank_select_high, bank_select_low};
   assign read_ok = cmd == CMD_READ && banks_open[bank];
   // Latency is only visible on the pins when the mode is loaded
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lat3_q <= 1'b0;
      end else if (cmd == CMD_LOAD_MODE) begin
         lat3_q <= addr[LAT_MSB:LAT_LSB] == LAT_THREE;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   chk_reset_idle: assert property ($rose(rst_n) |-> dq_oe_n == 2'h3 && banks_open == 4'h0)
      else $error("outputs busy right after reset");
   chk_active_opens: assert property (cmd == CMD_ACTIVE |=> banks_open[$past(bank)])
      else $error("active did not open bank");
   chk_pre_one: assert property (cmd == CMD_PRECHARGE && !addr[AP_BIT] |=> !banks_open[$past(bank)])
      else $error("precharge left bank open");
   chk_pre_all: assert property (cmd == CMD_PRECHARGE && addr[AP_BIT] |=> banks_open == 4'h0)
      else $error("precharge all left a bank open");
   chk_read_lat_two: assert property (read_ok && !lat3_q |-> ##2 dq_oe_n == 2'h0)
      else $error("read data late at latency two");
   chk_read_lat_three: assert property (read_ok && lat3_q |-> ##2 dq_oe_n == 2'h3 ##1 dq_oe_n == 2'h0)
      else $error("read data timing wrong at latency three");
   chk_refresh_done: assert property ($rose(init_refresh_done) |-> $past(cmd) == CMD_REFRESH)
      else $error("refresh status rose without refresh");
   chk_mode_loads: assert property (init_refresh_done && cmd == CMD_LOAD_MODE |-> ##[1:2] mode_loaded)
      else $error("mode load not reported");
   chk_mode_holds: assert property (mode_loaded |=> mode_loaded)
      else $error("mode status dropped");
endmodule : sdram_burst_core_monitor
`default_nettype wire

// [verification/sdram_ctrl_model.sv]
// Memory controller model issuing one command per sys_clk cycle.
// Assumes callers start 1 ns after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module sdram_ctrl_model
   import sdram_core_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Command pins
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [11:0] addr,
   output logic bank_select_low,
   output logic bank_select_high,
   // Write data
   output logic [15:0] dq_in
);
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      addr = 12'h000;
      {bank_select_high, bank_select_low} = 2'h0;
      dq_in = 16'h0000;
   end
   task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a, input logic [15:0] d);
      {cs_n, ras_n, cas_n, we_n} = c;
      {bank_select_high, bank_select_low} = b;
      addr = a;
      dq_in = d;
      @(posedge sys_clk);
      #1;
   endtask : cmd
   // Data lines outside a write toggle so stale values cannot pass as data
   task automatic op(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
      cmd(c, b, a, ~dq_in);
   endtask : op
   task automatic idle();
      op(CMD_NOP, 2'h0, 12'h000);
   endtask : idle
   task automatic init_seq();
      repeat (4) idle();
      op(CMD_PRECHARGE, 2'h0, 12'h400);
      repeat (2) op(CMD_REFRESH, 2'h0, 12'h000);
   endtask : init_seq
   task automatic load_mode(input logic [2:0] bl, input logic typ, input logic [2:0] lat, input logic wb);
      op(CMD_PRECHARGE, 2'h0, 12'h400);
      op(CMD_LOAD_MODE, 2'h0, {2'h0, wb, 2'h0, lat, typ, bl});
      idle();
      op(CMD_ACTIVE, 2'h0, 12'h000);
      op(CMD_ACTIVE, 2'h1, 12'h000);
      idle();
   endtask : load_mode
endmodule : sdram_ctrl_model
`default_nettype wire

// [verification/sdram_burst_core_test.sv]
// Self-checking bench: bursts compared with a reference memory.
// Assumes the controller model and monitor are compiled first.
`timescale 1ns/1ns
`default_nettype none
module sdram_burst_core_test;
   import sdram_core_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b1;
   logic cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high;
   logic [11:0] addr;
   logic [15:0] dq_in, dq_out;
   logic [1:0] dq_oe_n;
   logic write_buffer_ready, init_refresh_done, mode_loaded;
   logic [3:0] banks_open;
   logic [31:0] seed = 32'hcbbe3268;
   logic [15:0] mem [int];
   int fail_count = 0;
   int n_checks = 0;
   int base;
   always #25 sys_clk = ~sys_clk;
   sdram_ctrl_model ctrl (.sys_clk(sys_clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
      .bank_select_low(bank_select_low), .bank_select_high(bank_select_high), .dq_in(dq_in));
   // Fewer rows keep the array small; full columns keep page wrap real
   sdram_burst_core #(.NUM_ROW_BITS(4)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .addr(addr), .bank_select_low(bank_select_low),
      .bank_select_high(bank_select_high), .dqm(2'h0), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
      .write_buffer_ready(write_buffer_ready), .init_refresh_done(init_refresh_done), .mode_loaded(mode_loaded),
      .banks_open(banks_open));
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd
   function automatic int col_at(int start, int k, int len, bit typ);
      int off;
      off = start % len;
      return start - off + (typ ? (off ^ k) : (off + k) % len);
   endfunction : col_at
   task automatic check_data(input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected data at %0t: %h vs %h", $time, exp, got);
      end
   endtask : check_data
   task automatic check_bits(input logic [3:0] exp, input logic [3:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected flags at %0t: %h vs %h", $time, exp, got);
      end
   endtask : check_bits
   task automatic do_write(int bank, int start, int len, bit typ, bit term);
      logic [31:0] r;
      for (int k = 0; k < len; k++) begin
         r = rnd();
         mem[bank * 512 + col_at(start, k, term ? 512 : len, typ)] = r[15:0];
         ctrl.cmd(k == 0 ? CMD_WRITE : CMD_NOP, bank[1:0], k == 0 ? start[11:0] : 12'h000, r[15:0]);
      end
      if (term) ctrl.op(CMD_TERMINATE, 2'h0, 12'h000);
      repeat (10) ctrl.idle();
   endtask : do_write
   task automatic do_read(int bank, int start, int len, bit typ, int m, bit term, bit ap, int prev);
      ctrl.op(CMD_READ, bank[1:0], {1'b0, ap, 1'b0, start[8:0]});
      if (prev >= 0) check_data(prev[15:0], dq_out);
      for (int j = 1; j < len + m; j++) begin
         ctrl.op(term && j == len ? CMD_TERMINATE : CMD_NOP, 2'h0, 12'h000);
         if (j >= m - 1 && j < len + m - 1) begin
            check_data(mem[bank * 512 + col_at(start, j - m + 1, term ? 512 : len, typ)], dq_out);
            check_bits(4'h0, {2'h0, dq_oe_n});
         end
      end
      check_bits(4'h3, {2'h0, dq_oe_n});
   endtask : do_read
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      #5 rst_n = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      check_bits(4'h3, {init_refresh_done, mode_loaded, write_buffer_ready, 1'b1});
      check_bits(4'h3, {2'h0, dq_oe_n});
      rst_n = 1'b1;
      ctrl.init_seq();
      check_bits(4'hb, {init_refresh_done, mode_loaded, write_buffer_ready, 1'b1});
      ctrl.load_mode(BL_ONE, 1'b0, LAT_TWO, 1'b0);
      check_bits(4'hf, {init_refresh_done, mode_loaded, write_buffer_ready, 1'b1});
      check_bits(4'h3, banks_open);
      // Every fixed length with both orders; latency three on a few of them
      for (int i = 0; i < 8; i++) begin
         ctrl.load_mode(3'(i / 2), i[0], i % 3 == 1 ? LAT_THREE : LAT_TWO, 1'b0);
         base = rnd() % 512;
         do_write(0, base, 1 << (i / 2), i[0], 1'b0);
         do_read(0, base ^ (rnd() % (1 << (i / 2))), 1 << (i / 2), i[0], i % 3 == 1 ? 3 : 2, 1'b0, 1'b0, -1);
      end
      base = base - base % 8;
      ctrl.load_mode(BL_EIGHT, 1'b0, LAT_THREE, 1'b1);
      do_write(0, base + 5, 1, 1'b0, 1'b0);
      do_read(0, base, 8, 1'b0, 3, 1'b0, 1'b1, -1);
      check_bits(4'h2, banks_open);
      ctrl.op(CMD_READ, 2'h0, base[11:0]);
      repeat (4) begin
         ctrl.idle();
         check_bits(4'h3, {2'h0, dq_oe_n});
      end
      ctrl.load_mode(BL_TWO, 1'b0, LAT_TWO, 1'b0);
      ctrl.op(CMD_READ, 2'h0, base[11:0] + 12'h003);
      do_read(0, base + 6, 2, 1'b0, 2, 1'b0, 1'b0, mem[base + 3]);
      ctrl.load_mode(BL_PAGE, 1'b0, LAT_TWO, 1'b0);
      do_write(1, 510, 4, 1'b0, 1'b1);
      do_read(1, 510, 4, 1'b0, 2, 1'b1, 1'b0, -1);
      ctrl.op(CMD_PRECHARGE, 2'h1, 12'h000);
      ctrl.idle();
      check_bits(4'h1, banks_open);
      tally_and_finish();
   end
   initial begin
      #200000;
      fail_count++;
      tally_and_finish();
   end
endmodule : sdram_burst_core_test
bind sdram_burst_core sdram_burst_core_monitor mon (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .ras_n(ras_n),
   .cas_n(cas_n), .we_n(we_n), .addr(addr), .bank_select_low(bank_select_low), .bank_select_high(bank_select_high),
   .dq_oe_n(dq_oe_n), .init_refresh_done(init_refresh_done), .mode_loaded(mode_loaded), .banks_open(banks_open));
`default_nettype wire
